// ===== logic/dfm_pkg.sv
// Shared constants and types for the DSP firmware memory controller
package dfm_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [21:0] IDX_CONTROL = 22'h001100;
	localparam logic [21:0] IDX_CLOCKING = 22'h001101;
	localparam logic [21:0] IDX_STATUS = 22'h001104;
	localparam logic [21:0] IDX_CLK_STATUS = 22'h001105;
	localparam int CTL_START_BIT = 0;
	localparam int CTL_CORE_BIT = 1;
	localparam int CTL_CLKEN_BIT = 2;
	localparam int CTL_MEMEN_BIT = 4;
	localparam int STATUS_READY_BIT = 0;
	localparam logic CTL_MEMEN_RESET = 1'h1;
	localparam logic [2:0] CLK_SEL_RESET = 3'h0;
	// ----------------------------------------------------------------
	// Memory windows, in register indices
	// ----------------------------------------------------------------
	localparam logic [21:0] PM_BASE = 22'h100000;
	localparam logic [21:0] PM_LAST = 22'h105FFF;
	localparam logic [21:0] CM_BASE = 22'h180000;
	localparam logic [21:0] CM_LAST = 22'h1807FF;
	localparam logic [21:0] XM_BASE = 22'h190000;
	localparam logic [21:0] XM_LAST = 22'h1947FF;
	localparam logic [21:0] YM_BASE = 22'h1A8000;
	localparam logic [21:0] YM_LAST = 22'h1A97FF;
	localparam int MEM_DEPTH [4] = '{8192, 1024, 9216, 3072};
	localparam int MEM_LANES [4] = '{3, 2, 2, 2};
	localparam int CLEAR_WORDS = 9216;
	localparam logic [21:0] PM_REGS_PER_WORD = 22'h000003;
	// ----------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------
	localparam logic [1:0] RATE_FAMILY_44K1 = 2'h1;
	localparam logic [2:0] SEL_CAP = 3'h2;
	localparam logic [2:0] SEL_TOP = 3'h3;
	localparam logic [25:0] FREQ_48K_BASE_HZ = 26'd6144000;
	localparam logic [25:0] FREQ_44K_BASE_HZ = 26'd5644800;
	localparam int unsigned SYS_CLK_HZ = 25000000;
	// ----------------------------------------------------------------
	// Bus answers and types
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {RG_NONE, RG_PROG, RG_COEF, RG_XDAT, RG_YDAT, RG_REG} dfm_region_t;
	typedef struct packed {
		dfm_region_t region;
		logic [13:0] word;
		logic [1:0] lane;
	} dfm_loc_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WRITE, ST_BRESP, ST_RD_MEM, ST_RD_DATA, ST_RRESP, ST_CLEAR
	} dfm_state_t;
endpackage

// ===== logic/dfm_lane_mem.sv
// Word memory built from 16-bit lanes with per-lane write enables
`timescale 1ns/1ns
`default_nettype none
module dfm_lane_mem #(
	parameter int LANES = 2,
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	input wire logic clock_i,
	input wire logic en_i,
	input wire logic [LANES-1:0] we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [LANES*16-1:0] wdata_i,
	output logic [LANES*16-1:0] rdata_o
);
	// No reset on the array: contents survive a reset of the logic
	logic [LANES*16-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW) || LANES < 1) begin : g_bad
		$error("dfm_lane_mem: depth does not fit address width");
	end

	always_ff @(posedge clock_i) begin
		if (en_i) begin
			for (int i = 0; i < LANES; i++) begin
				if (we_i[i]) begin
					mem[addr_i][i*16 +: 16] <= wdata_i[i*16 +: 16];
				end
			end
			rdata_o <= mem[addr_i];
		end
	end
endmodule
`default_nettype wire

// ===== logic/dfm_firmware_ctrl.sv
// DSP firmware memory controller with AXI4-Lite register access
//
// Notes on behaviour
// - Program window holds 8192 words.
// - Coefficient window holds 1024 words.
// - X and Y data windows mapped.
// - Program word spans three registers.
// - Coefficient/data word spans two registers.
// - Memory access needs processor clock running.
// - Select code picks processor clock rate.
// - 44.1k family uses lower rates.
// - Without high-rate allow, cap at code two.
// - Memory enable gates all bus memory access.
// - Ready flag reports memory accessible.
// - Ready rise feeds interrupt controller.
// - Ready selectable onto general purpose pin.
// - Resets leave memory contents alone.
// - Sleep or low supply clears memory.
// - Core enable plus start pulses the execution start trigger.
// - Execution needs core enable, not start.
`timescale 1ns/1ns
`default_nettype none
module dfm_firmware_ctrl #(
	parameter int ADDR_W = 24
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [4:0] sample_rate_code_i,
	input wire logic subsystem_high_rate_allow_i,
	input wire logic sleep_entry_i,
	input wire logic core_supply_low_i,
	input wire logic gpio_ready_select_i,
	output logic firmware_ram_ready_o,
	output logic ram_ready_event_o,
	output logic gpio_ram_ready_o,
	output logic [25:0] processor_clock_hz_o,
	output logic processor_tick_o,
	output logic processor_run_o,
	output logic execution_start_trigger_o
);
	// Register index is taken from byte address bits 23:2
	if (ADDR_W < 24 || ADDR_W > 32) begin : g_bad
		$error("dfm_firmware_ctrl: address width must be 24 to 32");
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic dfm_pkg::dfm_loc_t locate(input logic [21:0] idx);
		logic [21:0] off;
		dfm_pkg::dfm_loc_t l;
		l.region = dfm_pkg::RG_NONE;
		l.word = '0;
		l.lane = '0;
		off = '0;
		if (idx >= dfm_pkg::PM_BASE && idx <= dfm_pkg::PM_LAST) begin
			off = idx - dfm_pkg::PM_BASE;
			l.region = dfm_pkg::RG_PROG;
			l.word = 14'(off / dfm_pkg::PM_REGS_PER_WORD);
			l.lane = 2'h2 - 2'(off % dfm_pkg::PM_REGS_PER_WORD);
		end else begin
			if (idx >= dfm_pkg::CM_BASE && idx <= dfm_pkg::CM_LAST) begin
				off = idx - dfm_pkg::CM_BASE;
				l.region = dfm_pkg::RG_COEF;
			end else if (idx >= dfm_pkg::XM_BASE && idx <= dfm_pkg::XM_LAST) begin
				off = idx - dfm_pkg::XM_BASE;
				l.region = dfm_pkg::RG_XDAT;
			end else if (idx >= dfm_pkg::YM_BASE && idx <= dfm_pkg::YM_LAST) begin
				off = idx - dfm_pkg::YM_BASE;
				l.region = dfm_pkg::RG_YDAT;
			end else if (idx == dfm_pkg::IDX_CONTROL || idx == dfm_pkg::IDX_CLOCKING ||
				idx == dfm_pkg::IDX_STATUS || idx == dfm_pkg::IDX_CLK_STATUS) begin
				l.region = dfm_pkg::RG_REG;
			end
			if (l.region != dfm_pkg::RG_REG && l.region != dfm_pkg::RG_NONE) begin
				l.word = 14'(off >> 1);
				l.lane = {1'b0, ~off[0]};
			end
		end
		return l;
	endfunction

	function automatic logic is_mem(input dfm_pkg::dfm_region_t r);
		return r != dfm_pkg::RG_NONE && r != dfm_pkg::RG_REG;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dfm_pkg::dfm_state_t state;
	logic firmware_memory_enable;
	logic processor_clock_enable;
	logic processor_core_enable;
	logic [2:0] processor_clock_select;
	logic [2:0] eff_sel;
	logic family_44k1;
	logic aw_held;
	logic w_held;
	logic [21:0] aw_idx;
	logic [21:0] ar_idx;
	logic [15:0] w_data;
	logic [1:0] w_strb;
	logic clear_pending;
	logic sleep_seen;
	logic [13:0] clr_cnt;
	logic [24:0] phase;
	logic [47:0] mem_rd [4];
	logic mem_ok;
	logic ar_take;
	logic write_go;
	logic clear_go;
	logic next_aw_held;
	logic next_w_held;
	logic next_ready;
	logic power_down;
	dfm_pkg::dfm_loc_t wloc;
	dfm_pkg::dfm_loc_t rloc;
	dfm_pkg::dfm_loc_t acc;

	assign wloc = locate(aw_idx);
	assign rloc = locate(ar_idx);
	assign acc = (state == dfm_pkg::ST_WRITE) ? wloc : rloc;
	assign power_down = sleep_entry_i | core_supply_low_i;
	assign mem_ok = firmware_ram_ready_o & processor_clock_enable
		& firmware_memory_enable;
	assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
	// A committed read address wins over a pending write or sweep
	assign clear_go = state == dfm_pkg::ST_IDLE && clear_pending && !ar_take;
	assign write_go = state == dfm_pkg::ST_IDLE && aw_held && w_held && !ar_take && !clear_pending;
	assign next_aw_held = write_go ? 1'b0 : (aw_held | (s_axi_awvalid_i & s_axi_awready_o));
	assign next_w_held = write_go ? 1'b0 : (w_held | (s_axi_wvalid_i & s_axi_wready_o));
	assign next_ready = processor_clock_enable & firmware_memory_enable & !power_down
		& !clear_pending & !clear_go & state != dfm_pkg::ST_CLEAR;

	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_mem
		localparam int LN = dfm_pkg::MEM_LANES[g];
		localparam int AW = $clog2(dfm_pkg::MEM_DEPTH[g]);
		logic sel;
		logic en;
		logic [LN-1:0] we;
		logic [AW-1:0] addr;
		logic [LN*16-1:0] wdata;
		logic [LN*16-1:0] rd;
		assign sel = acc.region == dfm_pkg::dfm_region_t'(g + 1);
		always_comb begin
			en = 1'b0;
			we = '0;
			addr = acc.word[AW-1:0];
			wdata = {LN{w_data}};
			if (state == dfm_pkg::ST_CLEAR) begin
				addr = clr_cnt[AW-1:0];
				wdata = '0;
				if (int'(clr_cnt) < dfm_pkg::MEM_DEPTH[g]) begin
					en = 1'b1;
					we = '1;
				end
			end else if (sel && mem_ok) begin
				if (state == dfm_pkg::ST_RD_MEM) begin
					en = 1'b1;
				end else if (state == dfm_pkg::ST_WRITE && w_strb == 2'h3) begin
					en = 1'b1;
					we = LN'(1) << acc.lane;
				end
			end
		end
		dfm_lane_mem #(.LANES(LN), .DEPTH(dfm_pkg::MEM_DEPTH[g]), .AW(AW)) u_mem (
			.clock_i(clock_i),
			.en_i(en),
			.we_i(we),
			.addr_i(addr),
			.wdata_i(wdata),
			.rdata_o(rd)
		);
		assign mem_rd[g] = 48'(rd);
	end

	// ----------------------------------------------------------------
	// Bus handshakes and sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			aw_idx <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready_o <= !next_aw_held;
			s_axi_wready_o <= !next_w_held;
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_idx <= s_axi_awaddr_i[23:2];
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i[15:0];
				w_strb <= s_axi_wstrb_i[1:0];
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= dfm_pkg::ST_IDLE;
			ar_idx <= '0;
			clr_cnt <= '0;
			s_axi_arready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= dfm_pkg::RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o <= dfm_pkg::RESP_OKAY;
			s_axi_rdata_o <= '0;
		end else begin
			s_axi_arready_o <= 1'b0;
			case (state)
				dfm_pkg::ST_IDLE: begin
					s_axi_arready_o <= !ar_take && !write_go && !clear_go
						&& !(next_aw_held && next_w_held) && !clear_pending;
					if (ar_take) begin
						ar_idx <= s_axi_araddr_i[23:2];
						state <= dfm_pkg::ST_RD_MEM;
					end else if (clear_go) begin
						clr_cnt <= '0;
						state <= dfm_pkg::ST_CLEAR;
					end else if (write_go) begin
						state <= dfm_pkg::ST_WRITE;
					end
				end
				dfm_pkg::ST_WRITE: begin
					s_axi_bvalid_o <= 1'b1;
					if (wloc.region == dfm_pkg::RG_NONE) begin
						s_axi_bresp_o <= dfm_pkg::RESP_DECERR;
					end else if (is_mem(wloc.region) && !mem_ok) begin
						s_axi_bresp_o <= dfm_pkg::RESP_SLVERR;
					end else begin
						s_axi_bresp_o <= dfm_pkg::RESP_OKAY;
					end
					state <= dfm_pkg::ST_BRESP;
				end
				dfm_pkg::ST_BRESP: begin
					if (s_axi_bready_i) begin
						s_axi_bvalid_o <= 1'b0;
						state <= dfm_pkg::ST_IDLE;
					end
				end
				dfm_pkg::ST_RD_MEM: begin
					state <= dfm_pkg::ST_RD_DATA;
				end
				dfm_pkg::ST_RD_DATA: begin
					s_axi_rvalid_o <= 1'b1;
					s_axi_rdata_o <= '0;
					s_axi_rresp_o <= dfm_pkg::RESP_OKAY;
					if (rloc.region == dfm_pkg::RG_NONE) begin
						s_axi_rresp_o <= dfm_pkg::RESP_DECERR;
					end else if (rloc.region == dfm_pkg::RG_REG) begin
						s_axi_rdata_o <= {16'h0000, reg_value(ar_idx)};
					end else if (!mem_ok) begin
						s_axi_rresp_o <= dfm_pkg::RESP_SLVERR;
					end else begin
						s_axi_rdata_o <= {16'h0000, lane_value(rloc)};
					end
					state <= dfm_pkg::ST_RRESP;
				end
				dfm_pkg::ST_RRESP: begin
					if (s_axi_rready_i) begin
						s_axi_rvalid_o <= 1'b0;
						state <= dfm_pkg::ST_IDLE;
					end
				end
				dfm_pkg::ST_CLEAR: begin
					clr_cnt <= clr_cnt + 14'h0001;
					if (int'(clr_cnt) == dfm_pkg::CLEAR_WORDS - 1) begin
						state <= dfm_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= dfm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Top register of each word keeps only its low byte
	function automatic logic [15:0] lane_value(input dfm_pkg::dfm_loc_t l);
		logic [47:0] w;
		logic [15:0] v;
		logic top;
		w = mem_rd[int'(l.region) - 1];
		v = w[l.lane*16 +: 16];
		top = (l.region == dfm_pkg::RG_PROG) ? (l.lane == 2'h2) : (l.lane == 2'h1);
		if (top) begin
			v[15:8] = 8'h00;
		end
		return v;
	endfunction

	function automatic logic [15:0] reg_value(input logic [21:0] idx);
		logic [15:0] v;
		v = '0;
		if (idx == dfm_pkg::IDX_CONTROL) begin
			v[dfm_pkg::CTL_MEMEN_BIT] = firmware_memory_enable;
			v[dfm_pkg::CTL_CLKEN_BIT] = processor_clock_enable;
			v[dfm_pkg::CTL_CORE_BIT] = processor_core_enable;
		end else if (idx == dfm_pkg::IDX_CLOCKING) begin
			v[2:0] = processor_clock_select;
		end else if (idx == dfm_pkg::IDX_STATUS) begin
			v[dfm_pkg::STATUS_READY_BIT] = firmware_ram_ready_o;
		end else if (idx == dfm_pkg::IDX_CLK_STATUS) begin
			v[3:0] = {family_44k1, eff_sel};
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Control register writes and execution
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			firmware_memory_enable <= dfm_pkg::CTL_MEMEN_RESET;
			processor_clock_enable <= 1'b0;
			processor_core_enable <= 1'b0;
			processor_clock_select <= dfm_pkg::CLK_SEL_RESET;
			execution_start_trigger_o <= 1'b0;
		end else begin
			execution_start_trigger_o <= 1'b0;
			if (state == dfm_pkg::ST_WRITE && w_strb[0]) begin
				if (aw_idx == dfm_pkg::IDX_CONTROL) begin
					firmware_memory_enable <= w_data[dfm_pkg::CTL_MEMEN_BIT];
					processor_clock_enable <= w_data[dfm_pkg::CTL_CLKEN_BIT];
					processor_core_enable <= w_data[dfm_pkg::CTL_CORE_BIT];
					// Start is write-only; pulses only with the core enabled
					execution_start_trigger_o <= w_data[dfm_pkg::CTL_START_BIT]
						& w_data[dfm_pkg::CTL_CORE_BIT];
				end else if (aw_idx == dfm_pkg::IDX_CLOCKING) begin
					processor_clock_select <= w_data[2:0];
				end
			end
		end
	end

	// Execution is held by the core, clock and memory enables together, so firmware needs no start
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			processor_run_o <= 1'b0;
		end else begin
			processor_run_o <= processor_core_enable & processor_clock_enable
				& firmware_memory_enable;
		end
	end

	// ----------------------------------------------------------------
	// Processor clock rate and enable pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			eff_sel <= dfm_pkg::CLK_SEL_RESET;
			family_44k1 <= 1'b0;
			processor_clock_hz_o <= '0;
		end else begin
			logic [2:0] s;
			logic fam;
			s = (processor_clock_select > dfm_pkg::SEL_TOP) ? dfm_pkg::SEL_TOP
				: processor_clock_select;
			if (!subsystem_high_rate_allow_i && s > dfm_pkg::SEL_CAP) begin
				s = dfm_pkg::SEL_CAP;
			end
			fam = sample_rate_code_i[4:3] == dfm_pkg::RATE_FAMILY_44K1;
			eff_sel <= s;
			family_44k1 <= fam;
			processor_clock_hz_o <= (fam ? dfm_pkg::FREQ_44K_BASE_HZ
				: dfm_pkg::FREQ_48K_BASE_HZ) << s;
		end
	end

	// Rates above the system clock saturate at one pulse per cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			phase <= '0;
			processor_tick_o <= 1'b0;
		end else begin
			logic [26:0] sum;
			// One bit wider so a rate step up cannot wrap the sum
			sum = 27'(phase) + 27'(processor_clock_hz_o);
			processor_tick_o <= 1'b0;
			if (!processor_clock_enable) begin
				phase <= '0;
			end else if (sum >= 27'(dfm_pkg::SYS_CLK_HZ)) begin
				phase <= (processor_clock_hz_o >= 26'(dfm_pkg::SYS_CLK_HZ)) ? '0
					: 25'(sum - 27'(dfm_pkg::SYS_CLK_HZ));
				processor_tick_o <= 1'b1;
			end else begin
				phase <= 25'(sum);
			end
		end
	end

	// ----------------------------------------------------------------
	// Ready flag, sweep request, event and pin
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_seen <= 1'b0;
			clear_pending <= 1'b0;
		end else begin
			sleep_seen <= power_down;
			// New request wins over the take of an older one
			if (power_down && !sleep_seen) begin
				clear_pending <= 1'b1;
			end else if (clear_go) begin
				clear_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			firmware_ram_ready_o <= 1'b0;
			ram_ready_event_o <= 1'b0;
			gpio_ram_ready_o <= 1'b0;
		end else begin
			firmware_ram_ready_o <= next_ready;
			ram_ready_event_o <= next_ready & !firmware_ram_ready_o;
			gpio_ram_ready_o <= gpio_ready_select_i & next_ready;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence s_ar_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	sequence s_read_done;
		##3 s_axi_rvalid_o;
	endsequence

	a_read_latency: assert property (s_ar_taken |-> s_read_done)
		else $error("read answer not three cycles after address");
	a_ready_enables: assert property (firmware_ram_ready_o
		|-> $past(processor_clock_enable) && $past(firmware_memory_enable))
		else $error("ready set without both enables");
	a_rate_cap: assert property (!$past(subsystem_high_rate_allow_i)
		|-> eff_sel <= dfm_pkg::SEL_CAP)
		else $error("clock rate above cap without allow");
	a_family_rate: assert property (family_44k1 && eff_sel == 3'h0
		|-> processor_clock_hz_o == 26'd5644800)
		else $error("44.1k family lowest rate wrong");
	a_top_rate: assert property (!family_44k1 && eff_sel == 3'h3
		|-> processor_clock_hz_o == 26'd49152000)
		else $error("top rate wrong");
	a_run_core: assert property (processor_run_o |-> $past(processor_core_enable))
		else $error("running without core enable");
	a_ready_event: assert property ($rose(firmware_ram_ready_o) |-> ram_ready_event_o)
		else $error("ready rise without event");
	a_sweep_ready: assert property (state == dfm_pkg::ST_CLEAR |=> !firmware_ram_ready_o)
		else $error("ready during memory clear");
	a_gated_write: assert property (state == dfm_pkg::ST_WRITE && is_mem(wloc.region)
		&& !firmware_memory_enable |=> s_axi_bresp_o == dfm_pkg::RESP_SLVERR)
		else $error("memory write accepted while disabled");
	a_start_pulse: assert property (execution_start_trigger_o
		|=> !execution_start_trigger_o ##0 processor_core_enable [*1])
		else $error("start trigger not a single pulse with core on");
endmodule
`default_nettype wire

// ===== verif/dfm_host_model.sv
// Host-side AXI4-Lite master model with register access tasks
`timescale 1ns/1ns
`default_nettype none
module dfm_host_model (
	input wire logic clock_i,
	input wire logic awready_i,
	input wire logic wready_i,
	input wire logic bvalid_i,
	input wire logic [1:0] bresp_i,
	input wire logic arready_i,
	input wire logic rvalid_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	output logic [23:0] awaddr_o,
	output logic awvalid_o,
	output logic [31:0] wdata_o,
	output logic wvalid_o,
	output logic bready_o,
	output logic [23:0] araddr_o,
	output logic arvalid_o,
	output logic rready_o
);
	initial {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
	// Address and data released independently, each on its own take
	task automatic wr(input logic [21:0] idx, input logic [15:0] v, output logic [1:0] r);
		awaddr_o <= {idx, 2'h0};
		wdata_o <= {16'h0000, v};
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		do begin
			@(posedge clock_i);
			if (awvalid_o && awready_i) awvalid_o <= 1'b0;
			if (wvalid_o && wready_i) wvalid_o <= 1'b0;
		end while (!bvalid_i);
		r = bresp_i;
	endtask
	task automatic rd(input logic [21:0] idx, output logic [15:0] v, output logic [1:0] r);
		araddr_o <= {idx, 2'h0};
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		do begin
			@(posedge clock_i);
			if (arvalid_o && arready_i) arvalid_o <= 1'b0;
		end while (!rvalid_i);
		v = rdata_i[15:0];
		r = rresp_i;
	endtask
endmodule
`default_nettype wire

// ===== verif/dfm_firmware_memory_control_tb.sv
// Self-checking bench for the firmware memory controller
`timescale 1ns/1ns
`default_nettype none
module dfm_firmware_memory_control_tb;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] rate = 5'h00;
	logic allow = 1'b0;
	logic sleep = 1'b0;
	logic gpio_sel = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, awvalid, wvalid, bready, arvalid, rready;
	logic rdy, evt, gpo, tick, run, start;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, wdata;
	logic [23:0] awaddr, araddr;
	logic [25:0] hz, hz_exp;
	logic [15:0] d;
	logic [21:0] top;
	logic [21:0] last [4] = '{dfm_pkg::PM_LAST, dfm_pkg::CM_LAST, dfm_pkg::XM_LAST, dfm_pkg::YM_LAST};
	logic saw_ev = 1'b0;
	logic saw_start = 1'b0;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	always #20 clock_i = ~clock_i;
	dfm_host_model u_dfm_host_model (.clock_i(clock_i), .awready_i(awready), .wready_i(wready),
		.bvalid_i(bvalid), .bresp_i(bresp), .arready_i(arready), .rvalid_i(rvalid),
		.rdata_i(rdata), .rresp_i(rresp), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.wdata_o(wdata), .wvalid_o(wvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .rready_o(rready));
	dfm_firmware_ctrl u_dfm_firmware_ctrl (.clock_i(clock_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sample_rate_code_i(rate),
		.subsystem_high_rate_allow_i(allow), .sleep_entry_i(sleep), .core_supply_low_i(1'b0),
		.gpio_ready_select_i(gpio_sel), .firmware_ram_ready_o(rdy), .ram_ready_event_o(evt),
		.gpio_ram_ready_o(gpo), .processor_clock_hz_o(hz), .processor_tick_o(tick),
		.processor_run_o(run), .execution_start_trigger_o(start));
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [21:0] idx, input logic [15:0] v,
			input logic [1:0] er = dfm_pkg::RESP_OKAY);
		u_dfm_host_model.wr(idx, v, r);
		check("bresp", 32'(r), 32'(er));
	endtask
	task automatic rd(input logic [21:0] idx, input logic [15:0] v,
			input logic [1:0] er = dfm_pkg::RESP_OKAY);
		u_dfm_host_model.rd(idx, d, r);
		check("rresp", 32'(r), 32'(er));
		check("rdata", 32'(d), 32'(v));
	endtask
	// Pulses are one cycle wide, so they are latched here for later checks
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		saw_ev <= saw_ev | evt;
		saw_start <= saw_start | start;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(dfm_pkg::IDX_CONTROL, 16'h0010);
		rd(dfm_pkg::IDX_STATUS, 16'h0000);
		wr(dfm_pkg::PM_BASE, 16'h0001, dfm_pkg::RESP_SLVERR);
		wr(dfm_pkg::IDX_CONTROL, 16'h0014);
		gpio_sel <= 1'b1;
		rd(dfm_pkg::IDX_STATUS, 16'h0001);
		check("gpio", 32'(gpo), 32'h1);
		check("event", 32'(saw_ev), 32'h1);
		$display("test gating done");
		for (int i = 0; i < 4; i++) begin
			top = last[i] - 22'(dfm_pkg::MEM_LANES[i] - 1);
			wr(top, 16'hA5C3);
			wr(last[i], 16'h1234);
			rd(top, 16'h00C3);
			rd(last[i], 16'h1234);
			rd(last[i] + 22'h1, 16'h0000, dfm_pkg::RESP_DECERR);
		end
		$display("test windows done");
		wr(dfm_pkg::IDX_CONTROL, 16'h0004);
		rd(dfm_pkg::IDX_STATUS, 16'h0000);
		rd(dfm_pkg::CM_LAST, 16'h0000, dfm_pkg::RESP_SLVERR);
		wr(dfm_pkg::CM_LAST, 16'hFFFF, dfm_pkg::RESP_SLVERR);
		wr(dfm_pkg::IDX_CONTROL, 16'h0016);
		// Outputs launched at the answer edge settle one edge later
		@(posedge clock_i);
		check("run", 32'(run), 32'h1);
		check("start", 32'(saw_start), 32'h0);
		wr(dfm_pkg::IDX_CONTROL, 16'h0017);
		@(posedge clock_i);
		check("start", 32'(saw_start), 32'h1);
		rd(dfm_pkg::IDX_CONTROL, 16'h0016);
		wr(dfm_pkg::IDX_CONTROL, 16'h0014);
		$display("test execution done");
		for (int s = 0; s < 8; s++) begin
			rate <= s[2] ? 5'h08 : 5'h00;
			allow <= (s != 7);
			wr(dfm_pkg::IDX_CLOCKING, 16'(s[1:0]));
			repeat (2) @(posedge clock_i);
			hz_exp = s[2] ? dfm_pkg::FREQ_44K_BASE_HZ : dfm_pkg::FREQ_48K_BASE_HZ;
			hz_exp = hz_exp << ((s == 7) ? 2 : s[1:0]);
			check("clock_hz", 32'(hz), 32'(hz_exp));
			if (s == 3) check("tick", 32'(tick), 32'h1);
		end
		$display("test clocking done");
		rst_i <= 1'b1;
		@(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		wr(dfm_pkg::IDX_CONTROL, 16'h0014);
		rd(dfm_pkg::IDX_STATUS, 16'h0001);
		rd(dfm_pkg::CM_LAST, 16'h1234);
		sleep <= 1'b1;
		repeat (2) @(posedge clock_i);
		sleep <= 1'b0;
		// Clear sweep is 9216 cycles, plus margin
		repeat (9300) @(posedge clock_i);
		u_dfm_host_model.rd(dfm_pkg::CM_LAST, d, r);
		check("cleared", 32'(d), 32'h0);
		$display("test retention done");
		test_done();
	end
endmodule
`default_nettype wire
